// ==== rtl/pcr_rate_adjust.sv ====
// Operation
// - Direction 1 adds the rate value to time each reference cycle.
// - Direction 0 subtracts the rate value from time each reference cycle.
// - Writing enable 1 starts a timed adjustment with programmed rate and direction.
// - Enable clears itself when the duration ends; reads 1 while running.
// - Writing enable 0 turns temporary adjustment off.
// - Rate is 30 bits of 2^-32 ns split high 14, low 16.
// - Each reference cycle time advances by 40 ns, plus or minus rate only while a timed run or continuous mode is adjusting.
// - A zero rate value disables continuous and temporary adjustment.
// - Duration is a 32-bit count of reference cycles in two words.
// - 802.1AS mode bit forwards every PTP packet to the host port.
// - Bit 6 enables 1588 mode, set after reset.
// - Bits 5,4,3 enable raw Ethernet, IPv4 and IPv6 detection.
// - Bit 2 picks peer-to-peer when 1, end-to-end after reset.
// - Bit 1 makes host port master when 1, slave after reset.
// - Bit 0 picks one-step when 1, set after reset.
// - Time updates once per reference period with 8 ns sub-phase.
`default_nettype none

module pcr_rate_adjust
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Host register port
  input  wire logic [pcr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [pcr_pkg::DATA_W-1:0] reg_wdata,
  output logic      [pcr_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_rvalid,
  // Time outputs
  output logic      [pcr_pkg::NS_W-1:0]   rtc_ns,
  output logic      [pcr_pkg::FRAC_W-1:0] rtc_subns,
  output logic      [2:0]                 rtc_sub_phase,
  output logic                            rtc_update,
  output logic                            rate_adjusting,
  // Message handling configuration
  output logic                            as_fwd_all_host,
  output logic                            ptp1588_enable,
  output logic                            detect_raw_eth,
  output logic                            detect_ipv4_udp,
  output logic                            detect_ipv6_udp,
  output logic                            tc_peer_to_peer,
  output logic                            host_port_master,
  output logic                            one_step_mode
);
  import pcr_pkg::*;

  pcr_tick_if tk ();

  // Reference rate divider and temporary run timer
  pcr_ref_divider u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tk      (tk.divider)
  );

  pcr_adj_timer u_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tm      (tk.timer)
  );

  // Software-visible state
  logic                 rate_direction;
  logic [RATE_W-1:0]    rate;
  logic [DUR_W-1:0]     duration;
  logic [MSG_W-1:0]     msg_cfg;
  logic                 temp_spent;
  logic [ACC_W-1:0]     acc;

  // Address decode
  wire hit_rate_lo = (reg_addr == OFS_RATE_LOW);
  wire hit_rate_hi = (reg_addr == OFS_RATE_HIGH);
  wire hit_dur_lo  = (reg_addr == OFS_DUR_LOW);
  wire hit_dur_hi  = (reg_addr == OFS_DUR_HIGH);
  wire hit_msg     = (reg_addr == OFS_MSG_CFG);

  wire wr_rate_lo  = reg_wr && hit_rate_lo;
  wire wr_rate_hi  = reg_wr && hit_rate_hi;
  wire wr_dur_lo   = reg_wr && hit_dur_lo;
  wire wr_dur_hi   = reg_wr && hit_dur_hi;
  wire wr_msg      = reg_wr && hit_msg;

  // Rate value as it will stand after this cycle's write
  wire [RATE_W-1:0] next_rate =
    wr_rate_hi ? {reg_wdata[RATE_HI_MSB:0], rate[15:0]} :
    wr_rate_lo ? {rate[RATE_W-1:16], reg_wdata} : rate;
  wire next_rate_zero = (next_rate == '0);

  // Enable bit writes: a 1 with zero rate starts nothing
  wire temp_wr_one  = wr_rate_hi && reg_wdata[TEMP_EN_BIT];
  assign tk.start    = temp_wr_one && !next_rate_zero;
  assign tk.stop     = wr_rate_hi && !reg_wdata[TEMP_EN_BIT];
  assign tk.duration = duration;

  // Rate and direction registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_direction <= 1'b0;
      rate           <= '0;
    end else begin
      rate <= next_rate;
      if (wr_rate_hi) begin
        rate_direction <= reg_wdata[RATE_DIR_BIT];
      end
    end
  end

  // Duration words; changing them mid-run moves the end point
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duration <= {WORD_RESET, WORD_RESET};
    end else begin
      if (wr_dur_lo) begin
        duration[15:0] <= reg_wdata;
      end
      if (wr_dur_hi) begin
        duration[31:16] <= reg_wdata;
      end
    end
  end

  // After a timed run ends, continuous mode stays off until the rate is rewritten.
  // A finish landing in the same cycle as a rate write wins.
  wire rate_written = wr_rate_lo || wr_rate_hi;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_spent <= 1'b0;
    end else if (tk.done) begin
      temp_spent <= 1'b1;
    end else if (rate_written) begin
      temp_spent <= 1'b0;
    end
  end

  // Adjustment gating: timed run, or continuous when not spent
  wire rate_zero   = (rate == '0);
  wire cont_mode   = !tk.busy && !temp_spent;
  wire adjust_now  = !rate_zero && (tk.busy || cont_mode);

  // Per-period step of 40 ns plus or minus the rate
  wire [ACC_W-1:0] rate_ext  = {{(ACC_W-RATE_W){1'b0}}, rate};
  wire [ACC_W-1:0] step_add  = REF_STEP + rate_ext;
  wire [ACC_W-1:0] step_sub  = REF_STEP - rate_ext;
  wire [ACC_W-1:0] step      = !adjust_now     ? REF_STEP :
                               rate_direction ? step_add : step_sub;
  wire [ACC_W-1:0] next_acc  = acc + step;

  // Time accumulator steps once per reference period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= '0;
    end else if (tk.ref_tick) begin
      acc <= next_acc;
    end
  end

  assign rtc_ns    = acc[ACC_W-1:FRAC_W];
  assign rtc_subns = acc[FRAC_W-1:0];

  // Update strobe, sub-phase and adjusting status follow the tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_update     <= 1'b0;
      rtc_sub_phase  <= 3'h0;
      rate_adjusting <= 1'b0;
    end else begin
      rtc_update     <= tk.ref_tick;
      rtc_sub_phase  <= tk.sub_phase;
      if (tk.ref_tick) begin
        rate_adjusting <= adjust_now;
      end
    end
  end

  // Message configuration word; upper byte reserved
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_cfg <= MSG_CFG_RESET;
    end else if (wr_msg) begin
      msg_cfg <= reg_wdata[MSG_W-1:0];
    end
  end

  // Configuration bits go straight out of their flops
  assign as_fwd_all_host  = msg_cfg[MSG_AS_BIT];
  assign ptp1588_enable   = msg_cfg[MSG_1588_BIT];
  assign detect_raw_eth   = msg_cfg[MSG_ETH_BIT];
  assign detect_ipv4_udp  = msg_cfg[MSG_IPV4_BIT];
  assign detect_ipv6_udp  = msg_cfg[MSG_IPV6_BIT];
  assign tc_peer_to_peer  = msg_cfg[MSG_P2P_BIT];
  assign host_port_master = msg_cfg[MSG_MASTER_BIT];
  assign one_step_mode    = msg_cfg[MSG_ONE_STEP];

  // Read data select; enable bit shows the live run state
  wire [DATA_W-1:0] rd_rate_hi = {rate_direction, tk.busy, rate[RATE_W-1:16]};
  wire [DATA_W-1:0] rd_msg     = {8'h00, msg_cfg};
  wire [DATA_W-1:0] rd_sel     =
    hit_rate_lo ? rate[15:0]      :
    hit_rate_hi ? rd_rate_hi      :
    hit_dur_lo  ? duration[15:0]  :
    hit_dur_hi  ? duration[31:16] :
    hit_msg     ? rd_msg          : WORD_RESET;

  // Read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= WORD_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_sel;
      end
    end
  end
endmodule // pcr_rate_adjust

`default_nettype wire

// ==== rtl/pcr_pkg.sv ====
`default_nettype none

package pcr_pkg;

  // Host register port geometry
  localparam int          ADDR_W         = 11;
  localparam int          DATA_W         = 16;

  // Register byte offsets
  localparam logic [10:0] OFS_RATE_LOW   = 11'h610;
  localparam logic [10:0] OFS_RATE_HIGH  = 11'h612;
  localparam logic [10:0] OFS_DUR_LOW    = 11'h614;
  localparam logic [10:0] OFS_DUR_HIGH   = 11'h616;
  localparam logic [10:0] OFS_MSG_CFG    = 11'h620;

  // Rate high word and control fields
  localparam int          RATE_DIR_BIT   = 15;
  localparam int          TEMP_EN_BIT    = 14;
  localparam int          RATE_HI_MSB    = 13;
  localparam int          RATE_W         = 30;
  localparam int          DUR_W          = 32;

  // Message configuration fields
  localparam int          MSG_W          = 8;
  localparam int          MSG_AS_BIT     = 7;
  localparam int          MSG_1588_BIT   = 6;
  localparam int          MSG_ETH_BIT    = 5;
  localparam int          MSG_IPV4_BIT   = 4;
  localparam int          MSG_IPV6_BIT   = 3;
  localparam int          MSG_P2P_BIT    = 2;
  localparam int          MSG_MASTER_BIT = 1;
  localparam int          MSG_ONE_STEP   = 0;

  // Reset values
  localparam logic [7:0]  MSG_CFG_RESET  = 8'h59;
  localparam logic [15:0] WORD_RESET     = 16'h0000;

  // Timing: system clock, reference period and sub-phase grain
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          REF_PERIOD_NS  = 40;
  localparam int          SUB_PHASE_NS   = 8;
  localparam int          REF_DIV        = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          SUB_PHASES     = REF_PERIOD_NS / SUB_PHASE_NS;

  // Time accumulator: nanoseconds above 32 fraction bits of 2^-32 ns
  localparam int          NS_W           = 30;
  localparam int          FRAC_W         = 32;
  localparam int          ACC_W          = NS_W + FRAC_W;
  localparam logic [61:0] REF_STEP       = 62'(REF_PERIOD_NS) << FRAC_W;

endpackage

`default_nettype wire

// ==== rtl/pcr_tick_if.sv ====
`default_nettype none

// Reference tick and temporary adjustment timer signals
interface pcr_tick_if;
  logic        ref_tick;
  logic [2:0]  sub_phase;
  logic        start;
  logic        stop;
  logic [31:0] duration;
  logic        busy;
  logic        done;

  modport divider (output ref_tick, output sub_phase);
  modport timer   (input ref_tick, input start, input stop, input duration,
                   output busy, output done);
  modport core    (input ref_tick, input sub_phase, input busy, input done,
                   output start, output stop, output duration);
endinterface

`default_nettype wire

// ==== rtl/pcr_ref_divider.sv ====
`default_nettype none

module pcr_ref_divider
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Tick output
  pcr_tick_if.divider tk
);
  localparam logic [2:0] DIV_LAST = 3'(REF_DIV - 1);

  logic [2:0] cyc;
  wire        wrap = (cyc == DIV_LAST);

  // Reference period counter; tick marks the start of each period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cyc         <= 3'h0;
      tk.ref_tick <= 1'b0;
    end else begin
      cyc         <= wrap ? 3'h0 : cyc + 3'h1;
      tk.ref_tick <= wrap;
    end
  end

  // Sub-phase: 10 ns steps mapped onto 8 ns slots, the fifth slot never shows
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tk.sub_phase <= 3'h0;
    end else begin
      tk.sub_phase <= wrap ? 3'h0 : tk.sub_phase + 3'h1;
    end
  end
endmodule // pcr_ref_divider

`default_nettype wire

// ==== rtl/pcr_adj_timer.sv ====
`default_nettype none

module pcr_adj_timer
  import pcr_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Timer control and status
  pcr_tick_if.timer tm
);
  logic [DUR_W-1:0] count;
  wire  [DUR_W-1:0] count_inc = count + 32'h1;
  wire              last_tick = tm.busy && tm.ref_tick && (count_inc >= tm.duration);

  // Counts reference cycles of a temporary run; start beats end and stop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tm.busy <= 1'b0;
      tm.done <= 1'b0;
      count   <= 32'h0;
    end else begin
      tm.done <= 1'b0;
      if (tm.start) begin
        tm.busy <= 1'b1;
        count   <= 32'h0;
      end else if (tm.stop) begin
        tm.busy <= 1'b0;
      end else if (last_tick) begin
        tm.busy <= 1'b0;
        tm.done <= 1'b1;
      end else if (tm.busy && tm.ref_tick) begin
        count   <= count_inc;
      end
    end
  end
endmodule // pcr_adj_timer

`default_nettype wire

// ==== tb/pcr_rate_adjust_chk.sv ====
`default_nettype none

// Port-level timing and arithmetic relations of the rate trim block
module pcr_rate_adjust_chk
  import pcr_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  // Time outputs
  input wire logic [29:0] rtc_ns,
  input wire logic [31:0] rtc_subns,
  input wire logic [2:0]  rtc_sub_phase,
  input wire logic        rtc_update,
  input wire logic        rate_adjusting,
  // Configuration levels
  input wire logic        as_fwd_all_host,
  input wire logic        ptp1588_enable,
  input wire logic        detect_raw_eth,
  input wire logic        detect_ipv4_udp,
  input wire logic        detect_ipv6_udp,
  input wire logic        tc_peer_to_peer,
  input wire logic        host_port_master,
  input wire logic        one_step_mode
);
  timeunit 1ns;
  timeprecision 1ps;

  // Whole accumulator and config vector, so steps compare in one go
  wire logic [61:0] acc;
  wire logic [7:0]  cfg;
  assign acc = {rtc_ns, rtc_subns};
  assign cfg = {as_fwd_all_host, ptp1588_enable, detect_raw_eth, detect_ipv4_udp,
                detect_ipv6_udp, tc_peer_to_peer, host_port_master, one_step_mode};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Reads answered one cycle later, never unasked
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray answer");
  property p_rdata_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // One update per 40 ns reference period
  property p_period; rtc_update |=> !rtc_update [*3] ##1 rtc_update; endproperty
  a_period: assert property (p_period) else $error("update spacing");
  property p_sub; rtc_sub_phase <= 3'h3; endproperty
  a_sub: assert property (p_sub) else $error("sub-phase range");
  // Sub-phase walks 0 to 3 from each update, one slot per clock
  property p_sub_seq;
    rtc_update |-> rtc_sub_phase == 3'h0 ##1 rtc_sub_phase == 3'h1
                   ##1 rtc_sub_phase == 3'h2 ##1 rtc_sub_phase == 3'h3;
  endproperty
  a_sub_seq: assert property (p_sub_seq) else $error("sub-phase order");
  // Accumulator and update strobe leave the same edge, so they show together
  property p_change; $changed(acc) |-> rtc_update; endproperty
  a_change: assert property (p_change) else $error("time moved off tick");
  // Step size: plain period when idle, otherwise trimmed
  property p_step; rtc_update && !rate_adjusting |-> acc == $past(acc, 2) + REF_STEP;
  endproperty
  a_step: assert property (p_step) else $error("plain step wrong");
  property p_adj; rtc_update && rate_adjusting |-> acc != $past(acc, 2) + REF_STEP;
  endproperty
  a_adj: assert property (p_adj) else $error("rate not applied");
  property p_cfg; !$past(reg_wr) |-> $stable(cfg); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved unwritten");
endmodule // pcr_rate_adjust_chk

bind pcr_rate_adjust pcr_rate_adjust_chk u_chk (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_rdata,
  .reg_rvalid, .rtc_ns, .rtc_subns, .rtc_sub_phase, .rtc_update, .rate_adjusting,
  .as_fwd_all_host, .ptp1588_enable, .detect_raw_eth, .detect_ipv4_udp, .detect_ipv6_udp,
  .tc_peer_to_peer, .host_port_master, .one_step_mode);

`default_nettype wire

// ==== tb/tb_pcr_rate_adjust.sv ====
`default_nettype none

// Directed bench for rate trim, timed runs and message configuration
module tb_pcr_rate_adjust;
  timeunit 1ns;
  timeprecision 1ps;
  import pcr_pkg::*;

  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [10:0] reg_addr  = 11'h000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [29:0] rtc_ns;
  logic [31:0] rtc_subns;
  logic [2:0]  rtc_sub_phase;
  logic        rtc_update;
  logic        rate_adjusting;
  wire  [7:0]  cfg;
  logic [61:0] a0;
  logic [61:0] a1;
  int          fails = 0;
  int          samples_checked = 0;
  int          adj_n = 0;

  pcr_rate_adjust u_dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .rtc_ns, .rtc_subns, .rtc_sub_phase, .rtc_update,
    .rate_adjusting, .as_fwd_all_host(cfg[7]), .ptp1588_enable(cfg[6]),
    .detect_raw_eth(cfg[5]), .detect_ipv4_udp(cfg[4]), .detect_ipv6_udp(cfg[3]),
    .tc_peer_to_peer(cfg[2]), .host_port_master(cfg[1]), .one_step_mode(cfg[0]));

  always #5 clk = ~clk;

  // Ticks that carried the rate, to size a timed run
  always @(posedge clk) if (rtc_update === 1'b1 && rate_adjusting === 1'b1) adj_n <= adj_n + 1;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe held one edge, dropped on the taking edge
  task automatic wr(input logic [10:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, exp);
  endtask

  task automatic nxt(output logic [61:0] a);
    do begin
      @(posedge clk);
      #1;
    end while (rtc_update !== 1'b1);
    a = {rtc_ns, rtc_subns};
  endtask

  // One settled tick skipped, so stale adjust state cannot leak in
  task automatic step(input logic [61:0] exp);
    nxt(a0);
    nxt(a0);
    nxt(a1);
    chk(a1 - a0, exp);
    chk(rtc_sub_phase, 3'h0);
    chk(rate_adjusting, exp != REF_STEP);
  endtask

  task automatic t_reset;
    chk(cfg, 8'h59);
    rd(OFS_MSG_CFG, 16'h0059);
    rd(OFS_RATE_HIGH, 16'h0000);
    rd(OFS_DUR_LOW, 16'h0000);
    rd(OFS_DUR_HIGH, 16'h0000);
    $display("reset values done");
  endtask

  task automatic t_cfg;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_MSG_CFG, 16'hff00 | (16'h0001 << i));
      rd(OFS_MSG_CFG, 16'h0001 << i);
      chk(cfg, 8'h01 << i);
    end
    wr(11'h618, 16'hffff);
    rd(11'h618, 16'h0000);
    wr(OFS_MSG_CFG, 16'h0059);
    $display("message config done");
  endtask

  // Widest high field, both directions
  task automatic t_cont;
    wr(OFS_RATE_LOW, 16'h0002);
    wr(OFS_RATE_HIGH, 16'hbfff);
    step(REF_STEP + 62'h3fff0002);
    wr(OFS_RATE_HIGH, 16'h3fff);
    step(REF_STEP - 62'h3fff0002);
    rd(OFS_RATE_HIGH, 16'h3fff);
    $display("continuous trim done");
  endtask

  task automatic t_zero;
    wr(OFS_RATE_LOW, 16'h0000);
    wr(OFS_RATE_HIGH, 16'h4000);
    rd(OFS_RATE_HIGH, 16'h0000);
    step(REF_STEP);
    $display("zero rate done");
  endtask

  task automatic t_temp;
    int adj_base;
    wr(OFS_DUR_LOW, 16'h0003);
    wr(OFS_DUR_HIGH, 16'h0000);
    rd(OFS_DUR_LOW, 16'h0003);
    repeat (8) @(posedge clk);
    adj_base = adj_n;
    wr(OFS_RATE_HIGH, 16'hc001);
    rd(OFS_RATE_HIGH, 16'hc001);
    repeat (24) @(posedge clk);
    rd(OFS_RATE_HIGH, 16'h8001);
    chk(adj_n - adj_base, 3);
    step(REF_STEP);
    wr(OFS_DUR_LOW, 16'h0064);
    wr(OFS_RATE_HIGH, 16'hc001);
    repeat (8) @(posedge clk);
    wr(OFS_RATE_HIGH, 16'h8001);
    rd(OFS_RATE_HIGH, 16'h8001);
    step(REF_STEP + 62'h10000);
    $display("timed run done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_cfg;
    t_cont;
    t_zero;
    t_temp;
    complete_run;
  end

  // Whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run;
  end
endmodule // tb_pcr_rate_adjust

`default_nettype wire
